// ---- dv/dcaf_mem_model.sv ----
/*
  Behavioural memory on the channel's system-bus side: it accepts each
  presented cycle and reports the operand finished after a settable wait.
  Assumes one clock shared with the channel and a synchronous reset.
*/
`timescale 1ns/1ps

module dcaf_mem_model (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic bus_active_in,
  input wire logic bus_write_in,
  input wire logic [1:0] wait_in, // Extra wait cycles, zero is prompt
  output logic op_done_out,
  output logic op_write_out
);
  logic [2:0] cnt_r; // Cycles left before the operand ends
  logic wr_r; // Type of the cycle being served

  // Serve one cycle at a time; done is a single-cycle pulse
  always_ff @(posedge sys_clk_in) begin
    op_done_out <= 1'b0;
    // Outside the pulse the type line shows the inverse so it cannot be trusted
    op_write_out <= ~wr_r;
    if (reset_in) begin
      cnt_r <= 3'h0;
      wr_r <= 1'b0;
    end else if (bus_active_in) begin
      cnt_r <= {1'b0, wait_in} + 3'h1;
      wr_r <= bus_write_in;
    end else if (cnt_r == 3'h1) begin
      op_done_out <= 1'b1;
      op_write_out <= wr_r;
      cnt_r <= 3'h0;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
endmodule

// ---- dv/tb_dcaf_channel.sv ----
/*
  Self-checking bench for the channel address block: register tasks,
  bus cycles served by the memory model, and pointer step checks.
  Assumes the register map header and package of the design.
*/
`timescale 1ns/1ps
`include "dcaf_map.svh"

module tb_dcaf_channel;
  import dcaf_pkg::*;
  logic sys_clk_in = 1'b0, reset_in = 1'b1, wr_s = 1'b0, rd_s = 1'b0, ld_s = 1'b0, ld_dst = 1'b0;
  logic req = 1'b0, req_wr = 1'b0, done, done_wr, act, bwr;
  logic [1:0] wt = 2'h0; // Memory wait, alternated between prompt and slow
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, ld_d = 32'h0, rdat, baddr;
  logic [3:0] code;
  int err_total = 0, comparisons = 0, cycles = 0, i, d;
  logic [1:0] szt [7] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h3};
  logic [31:0] bst [7] = '{32'hF000_0000, 32'hF000_0002, 32'hF000_0001, 32'h8000_0000, 32'h8000_0003,
    32'h1, 32'h2};

  always #20 sys_clk_in = ~sys_clk_in;

  dcaf_channel dcaf_channel_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr), .wr_data_in(wd),
    .wr_strobe_in(wr_s), .rd_strobe_in(rd_s), .rd_data_out(rdat), .load_strobe_in(ld_s), .load_dst_in(ld_dst),
    .load_data_in(ld_d), .cycle_req_in(req), .cycle_write_in(req_wr), .op_done_in(done),
    .op_write_in(done_wr), .bus_addr_out(baddr), .space_code_out(code), .bus_active_out(act),
    .bus_write_out(bwr));
  dcaf_mem_model dcaf_mem_model_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .bus_active_in(act),
    .bus_write_in(bwr), .wait_in(wt), .op_done_out(done), .op_write_out(done_wr));

  // Step worked out from size code and low address bits
  function automatic logic [31:0] step(input logic [1:0] sz, input logic [31:0] a);
    if (sz == `DCAF_SZ_LONG) return (a[1:0] == 2'h0) ? 32'h4 : (a[0] ? 32'h1 : 32'h2);
    if (sz == `DCAF_SZ_WORD) return a[0] ? 32'h1 : 32'h2;
    return 32'h1;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    wr_s <= 1'b1; addr <= a; wd <= v;
    @(posedge sys_clk_in);
    wr_s <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    rd_s <= 1'b1; addr <= a;
    @(posedge sys_clk_in);
    rd_s <= 1'b0;
    #1 chk(nm, exp, rdat);
  endtask

  // One bus cycle, checked on presentation, then wait for the operand to end
  task automatic cyc(input logic w, input logic [31:0] ea, input logic [3:0] ec);
    @(posedge sys_clk_in);
    req <= 1'b1; req_wr <= w;
    @(posedge sys_clk_in);
    req <= 1'b0;
    #1 chk("bus addr", ea, baddr);
    chk("space code", {28'h0, ec}, {28'h0, code});
    chk("active/type", {1'b1, 30'h0, w}, {act, 30'h0, bwr});
    // Look at done just after each edge, once the model's pulse has settled
    for (d = 0; d < 10 && done !== 1'b1; d++) begin
      @(posedge sys_clk_in);
      #1;
    end
    chk("op done", 32'h1, {31'h0, done});
    @(posedge sys_clk_in);
    wt <= ~wt;
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rd("fc reset", `DCAF_OFS_FC, 32'h0); // space code clears
    rd("ctrl reset", `DCAF_OFS_CTRL, 32'h0);
    rd("unmapped", 8'h10, 32'h0);
    wr(`DCAF_OFS_FC, 32'hFFFF_FF89);
    rd("fc", `DCAF_OFS_FC, 32'h89); // eight bits kept
    $display("test reset_regs done");
    wr(`DCAF_OFS_CTRL, {30'h0, `DCAF_SZ_BYTE});
    wr(`DCAF_OFS_SRC, 32'hFFFF_FFFF);
    cyc(1'b0, 32'hFFFF_FFFF, 4'h9); // read uses source
    rd("src wrap", `DCAF_OFS_SRC, 32'h0); // silent wrap
    $display("test wrap done");
    // Every size code, source then destination with increment on
    for (i = 0; i < 7; i++) begin
      wr(`DCAF_OFS_CTRL, {26'h0, 2'h1, szt[i], szt[i]});
      wr(`DCAF_OFS_SRC, bst[i]);
      wr(`DCAF_OFS_DST, ~bst[i]);
      cyc(1'b0, bst[i], 4'h9);
      rd("src step", `DCAF_OFS_SRC, bst[i] + step(szt[i], bst[i]));
      cyc(1'b1, ~bst[i], 4'h8); // write uses destination
      rd("dst step", `DCAF_OFS_DST, ~bst[i] + step(szt[i], ~bst[i]));
    end
    $display("test steps done");
    wr(`DCAF_OFS_CTRL, 32'h0);
    wr(`DCAF_OFS_DST, 32'hFFFF_FFFF);
    cyc(1'b1, 32'hFFFF_FFFF, 4'h8);
    rd("dst hold", `DCAF_OFS_DST, 32'hFFFF_FFFF); // no increment
    $display("test dst_hold done");
    @(posedge sys_clk_in);
    ld_s <= 1'b1; ld_dst <= 1'b1; ld_d <= 32'h1234_5678;
    @(posedge sys_clk_in);
    ld_s <= 1'b0;
    rd("load refused", `DCAF_OFS_DST, 32'hFFFF_FFFF); // flag off ignores load
    wr(`DCAF_OFS_CTRL, 32'h20);
    @(posedge sys_clk_in);
    ld_s <= 1'b1; ld_dst <= 1'b1; ld_d <= 32'hA5A5_0003;
    @(posedge sys_clk_in);
    ld_dst <= 1'b0; ld_d <= 32'h0000_0006;
    @(posedge sys_clk_in);
    ld_s <= 1'b0;
    rd("load dst", `DCAF_OFS_DST, 32'hA5A5_0003);
    rd("load src", `DCAF_OFS_SRC, 32'h0000_0006);
    $display("test load done");
    complete_run();
  end
endmodule

// ---- rtl/dcaf_channel.sv ----
/*
  Address pointers and space-code register of one DMA channel, with a
  plain register port, the bus address and space-code outputs, and the
  pointer advance after each operand.
  Assumes the rest of the channel drives the cycle request and operand
  done strobes on this clock, and a special-handling controller drives
  the load port on this clock too.
*/
// The address-and-strobe port and the register addresses were chosen for this implementation.
// Operation
// - Pointers wrap to zero silently on overflow
// - Source steps one, two or four
// - Host or special controller loads pointers
// - Destination holds full 32-bit address
// - Write cycles drive destination pointer address
// - Destination increments or holds per control
// - Destination steps one, two or four
// - Space-code register, eight bits, resets zero
// - High nibble destination, low nibble source
// - Cycle shows source or destination code
`timescale 1ns/1ps
`include "dcaf_map.svh"

module dcaf_channel
  import dcaf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [31:0] rd_data_out,
  input wire logic load_strobe_in,
  input wire logic load_dst_in,
  input wire logic [31:0] load_data_in,
  input wire logic cycle_req_in,
  input wire logic cycle_write_in,
  input wire logic op_done_in,
  input wire logic op_write_in,
  output logic [31:0] bus_addr_out,
  output logic [3:0] space_code_out,
  output logic bus_active_out,
  output logic bus_write_out
);

  dcaf_state_t st_r; // Registered state
  dcaf_state_t st_nxt; // Next state
  logic [2:0] src_step; // Source step for the current pointer
  logic [2:0] dst_step; // Destination step for the current pointer
  logic host_src_wr; // Host writes the source pointer
  logic host_dst_wr; // Host writes the destination pointer
  logic ld_src; // Controller loads the source pointer
  logic ld_dst; // Controller loads the destination pointer
  logic src_adv; // Source pointer advances this cycle
  logic dst_adv; // Destination pointer advances this cycle

  // Step from operand size and low address bits; misaligned pointers
  // take smaller steps so that later operands land aligned
  function automatic logic [2:0] step_of(input logic [1:0] size, input logic [1:0] low);
    logic [2:0] s;
    s = `DCAF_STEP_1;
    if (size == `DCAF_SZ_LONG) begin
      if (low == 2'h0) begin
        s = `DCAF_STEP_4;
      end else if (low[0] == 1'b0) begin
        s = `DCAF_STEP_2;
      end
    end else if (size == `DCAF_SZ_WORD) begin
      if (low[0] == 1'b0) begin
        s = `DCAF_STEP_2;
      end
    end
    return s;
  endfunction

  assign src_step = step_of(st_r.ctrl[`DCAF_CTRL_SOURCE_OPERAND_SIZE_LO +: 2], st_r.src[1:0]);
  assign dst_step = step_of(st_r.ctrl[`DCAF_CTRL_DESTINATION_OPERAND_SIZE_LO +: 2], st_r.dst[1:0]);

  // Host register writes
  assign host_src_wr = wr_strobe_in && (addr_in == `DCAF_OFS_SRC);
  assign host_dst_wr = wr_strobe_in && (addr_in == `DCAF_OFS_DST);

  assign ld_src = load_strobe_in && st_r.ctrl[`DCAF_CTRL_SPECIAL] && !load_dst_in;
  assign ld_dst = load_strobe_in && st_r.ctrl[`DCAF_CTRL_SPECIAL] && load_dst_in;

  // Advance after a finished read or write operand
  assign src_adv = op_done_in && !op_write_in;
  // destination advance gated by increment control
  assign dst_adv = op_done_in && op_write_in && st_r.ctrl[`DCAF_CTRL_DINC];

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Read data stand for one cycle only
    st_nxt.rd_data = 32'h0000_0000;
    // Source pointer: host write beats a load, a load beats an advance
    if (host_src_wr) begin
      st_nxt.src = wr_data_in;
    end else if (ld_src) begin
      st_nxt.src = load_data_in;
    end else if (src_adv) begin
      st_nxt.src = st_r.src + {29'h0000_0000, src_step};
    end
    if (host_dst_wr) begin
      st_nxt.dst = wr_data_in;
    end else if (ld_dst) begin
      st_nxt.dst = load_data_in;
    end else if (dst_adv) begin
      st_nxt.dst = st_r.dst + {29'h0000_0000, dst_step};
    end
    if (wr_strobe_in && (addr_in == `DCAF_OFS_FC)) begin
      st_nxt.fc = wr_data_in[7:0];
    end
    // Control register write
    if (wr_strobe_in && (addr_in == `DCAF_OFS_CTRL)) begin
      st_nxt.ctrl = wr_data_in[5:0];
    end
    // Register reads, unmapped offsets read zero
    if (rd_strobe_in) begin
      case (addr_in)
        `DCAF_OFS_SRC: st_nxt.rd_data = st_r.src;
        `DCAF_OFS_DST: st_nxt.rd_data = st_r.dst;
        `DCAF_OFS_FC: st_nxt.rd_data = {24'h00_0000, st_r.fc};
        `DCAF_OFS_CTRL: st_nxt.rd_data = {26'h000_0000, st_r.ctrl};
        default: st_nxt.rd_data = 32'h0000_0000;
      endcase
    end
    // Bus cycle presentation: active for one cycle, address, type and code held until the next request
    st_nxt.bus_active = cycle_req_in;
    if (cycle_req_in) begin
      st_nxt.bus_write = cycle_write_in;
      if (cycle_write_in) begin
        st_nxt.bus_addr = st_r.dst;
        st_nxt.space_code = st_r.fc[7:4];
      end else begin
        st_nxt.bus_addr = st_r.src;
        st_nxt.space_code = st_r.fc[3:0];
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st_r.src <= `DCAF_PTR_RST;
      st_r.dst <= `DCAF_PTR_RST;
      st_r.fc <= `DCAF_FC_RST;
      st_r.ctrl <= `DCAF_CTRL_RST;
      st_r.bus_addr <= 32'h0000_0000;
      st_r.space_code <= 4'h0;
      st_r.bus_active <= 1'b0;
      st_r.bus_write <= 1'b0;
      st_r.rd_data <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign rd_data_out = st_r.rd_data;
  assign bus_addr_out = st_r.bus_addr;
  assign space_code_out = st_r.space_code;
  assign bus_active_out = st_r.bus_active;
  assign bus_write_out = st_r.bus_write;

  // Quiet cycle: no register access or load touches a pointer
  logic quiet; // Helper for assertions
  assign quiet = !wr_strobe_in && !load_strobe_in;

  // Pointer wraps through zero
  chk_src_wrap: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quiet && src_adv && (st_r.src == 32'hFFFF_FFFF) |=> (st_r.src == 32'h0000_0000))
    else $error("source pointer did not wrap to zero");

  // Source step matches size and alignment
  chk_src_step: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quiet && src_adv |=> (st_r.src == $past(st_r.src) + {29'h0000_0000, $past(src_step)}))
    else $error("source pointer stepped wrongly");

  // Aligned long source steps by four
  chk_src_long: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (st_r.ctrl[1:0] == `DCAF_SZ_LONG) && (st_r.src[1:0] == 2'h0) |-> (src_step == 3'h4))
    else $error("aligned long source step is not four");

  // Special load only when the flag is set
  chk_load_gate: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !wr_strobe_in && load_strobe_in && !load_dst_in && !st_r.ctrl[5] && !op_done_in
    |=> $stable(st_r.src))
    else $error("source pointer loaded without special flag");

  // Write cycle shows the destination pointer and code
  chk_wr_addr: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    cycle_req_in && cycle_write_in |=> bus_active_out && bus_write_out
    && (bus_addr_out == $past(st_r.dst)) && (space_code_out == $past(st_r.fc[7:4])))
    else $error("write cycle address or code wrong");

  // Held destination stays put
  chk_dst_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quiet && op_done_in && op_write_in && !st_r.ctrl[4] |=> $stable(st_r.dst))
    else $error("destination moved while held");

  // Destination step matches size and alignment
  chk_dst_step: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    quiet && dst_adv |=> (st_r.dst == $past(st_r.dst) + {29'h0000_0000, $past(dst_step)}))
    else $error("destination pointer stepped wrongly");

  // Space codes zero after reset
  chk_fc_reset: assert property (@(posedge sys_clk_in)
    $past(reset_in) |-> (st_r.fc == 8'h00) && !bus_active_out)
    else $error("space codes not cleared by reset");

  // Read cycle shows the source pointer and code
  chk_rd_addr: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    cycle_req_in && !cycle_write_in |=> bus_active_out && !bus_write_out
    && (bus_addr_out == $past(st_r.src)) && (space_code_out == $past(st_r.fc[3:0])))
    else $error("read cycle address or code wrong");

  // Read data answer one cycle after the strobe
  chk_fc_read: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    rd_strobe_in && (addr_in == 8'h08) |=> (rd_data_out == {24'h00_0000, $past(st_r.fc)}))
    else $error("space-code read wrong");

  // Main scenarios
  cov_src_wrap: cover property (@(posedge sys_clk_in) disable iff (reset_in)
    src_adv && (st_r.src == 32'hFFFF_FFFF));
  cov_misaligned: cover property (@(posedge sys_clk_in) disable iff (reset_in)
    dst_adv && (dst_step == 3'h1) ##1 dst_adv && (dst_step == 3'h4));
  cov_special_load: cover property (@(posedge sys_clk_in) disable iff (reset_in) ld_dst);
  cov_rd_then_wr: cover property (@(posedge sys_clk_in) disable iff (reset_in)
    cycle_req_in && !cycle_write_in ##1 cycle_req_in && cycle_write_in);

endmodule

// ---- rtl/dcaf_map.svh ----
/*
  Register offsets, field positions, reset values and size codes for the
  DMA channel address and space-code block.
  Assumes byte addresses on an 8-bit register address port.
*/
`ifndef DCAF_MAP_SVH
`define DCAF_MAP_SVH

// Register byte offsets
`define DCAF_OFS_SRC 8'h00
`define DCAF_OFS_DST 8'h04
`define DCAF_OFS_FC 8'h08
`define DCAF_OFS_CTRL 8'h0C

// Reset values
`define DCAF_FC_RST 8'h00
`define DCAF_PTR_RST 32'h0000_0000
`define DCAF_CTRL_RST 6'h00

// Control register field positions
`define DCAF_CTRL_SOURCE_OPERAND_SIZE_LO 0
`define DCAF_CTRL_DESTINATION_OPERAND_SIZE_LO 2
`define DCAF_CTRL_DINC 4
`define DCAF_CTRL_SPECIAL 5

// Operand size codes
`define DCAF_SZ_LONG 2'h0
`define DCAF_SZ_BYTE 2'h1
`define DCAF_SZ_WORD 2'h2

// Pointer steps
`define DCAF_STEP_1 3'h1
`define DCAF_STEP_2 3'h2
`define DCAF_STEP_4 3'h4

`endif

// ---- rtl/dcaf_pkg.sv ----
/*
  Types for the DMA channel address and space-code block.
  Assumes the constants header is included by every user.
*/
package dcaf_pkg;

  // Whole state of the channel address block
  typedef struct packed {
    logic [31:0] src;        // Source pointer
    logic [31:0] dst;        // Destination pointer
    logic [7:0] fc;          // Space codes, destination high nibble
    logic [5:0] ctrl;        // Sizes, increment control, special flag
    logic [31:0] bus_addr;   // Address presented to the bus
    logic [3:0] space_code;  // Space code presented to the bus
    logic bus_active;        // A channel bus cycle is presented
    logic bus_write;         // Presented cycle is a write
    logic [31:0] rd_data;    // Register read data
  } dcaf_state_t;

endpackage
